// *** hdl/rtc_pkg.sv ***
// constants, register map and carriers of the battery-backed calendar clock
//
// Overview of operation
// - Seven calendar fields, each read and written as one byte of two BCD digits.
// - Timebase is a 32.768 kHz crystal; counting runs regardless of the bus.
// - Last day of month is 28, 29, 30 or 31 from month and year.
// - Calendar writes land only while control bit 0 is set; software sets it first.
// - In power-off the bus is isolated; oscillator, counters and alarm keep running.
// - An alarm match in normal operation raises only the alarm interrupt.
// - An alarm match in power-off raises wakeup as well as the alarm interrupt.
// - Alarm enable and the compared fields come only from the alarm control register.
// - Tick timer holds count and enable, counts down, interrupts at zero.
// - Tick period is (n+1)/128 second for programmed count n of 0 to 127.
// - Control register: count reset, merge select, clock select, access enable; reset zero.
// - Tick register: enable bit 7, count bits 6..0; running count not readable.
// - Alarm control: global enable bit 6, year..second enables bits 5..0.
`default_nettype none
package rtc_pkg;

  // crystal and derived rates
  localparam int XTAL_HZ = 32768;
  localparam int TICK_HZ = 128;
  localparam int SEC_DIVIDE = XTAL_HZ;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h40;
  localparam logic [7:0] TICK_OFF = 8'h44;
  localparam logic [7:0] ALM_CTRL_OFF = 8'h50;

  // calendar field index
  localparam int F_SEC = 0;
  localparam int F_MIN = 1;
  localparam int F_HOUR = 2;
  localparam int F_DATE = 3;
  localparam int F_WDAY = 4;
  localparam int F_MON = 5;
  localparam int F_YEAR = 6;
  localparam int NFIELD = 7;
  localparam int NALARM = 6;

  localparam logic [NFIELD-1:0][7:0] CAL_OFF = {8'h88, 8'h84, 8'h80, 8'h7C, 8'h78, 8'h74, 8'h70};
  localparam logic [NFIELD-1:0][7:0] CAL_RESET = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [NFIELD-1:0][7:0] CAL_MIN = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [NFIELD-1:0][7:0] CAL_MAX = {8'h99, 8'h12, 8'h07, 8'h31, 8'h23, 8'h59, 8'h59};
  localparam logic [NFIELD-1:0][7:0] CAL_MASK = {8'hFF, 8'h1F, 8'h07, 8'h3F, 8'h3F, 8'h7F, 8'h7F};

  // alarm data: second, minute, hour, date, month, year
  localparam logic [NALARM-1:0][7:0] ALM_OFF = {8'h68, 8'h64, 8'h60, 8'h5C, 8'h58, 8'h54};
  localparam logic [NALARM-1:0][7:0] ALM_RESET = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [NALARM-1:0][7:0] ALM_MASK = {8'hFF, 8'h1F, 8'h3F, 8'h3F, 8'h7F, 8'h7F};

  // month lengths
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;

  typedef struct packed {
    logic count_reset_bit;
    logic counter_merge_select;
    logic count_clock_select;
    logic cpu_access_enable;
  } ctrl_s;

  typedef struct packed {
    logic irq_en;
    logic [6:0] count;
  } tick_s;

  typedef struct packed {
    logic alarm_global_enable;
    logic [NALARM-1:0] field_en;
  } alarm_ctl_s;

  localparam ctrl_s CTRL_RESET = '0;
  localparam tick_s TICK_RESET = '0;
  localparam alarm_ctl_s ALM_CTL_RESET = '0;

endpackage
`default_nettype wire

// *** hdl/bcd_field.sv ***
// one two-digit bcd calendar field with load, wrap and carry
`timescale 1ns/1ns
`default_nettype none
module bcd_field #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic inc_en,
  input wire logic load_en,
  input wire logic [7:0] load_val,
  input wire logic [7:0] min_val,
  input wire logic [7:0] max_val,
  // state
  output logic [7:0] value,
  output logic carry
);
  logic [7:0] value_reg;
  logic [7:0] value_next;
  logic at_end;

  // at or past the last value wraps, so an out-of-range write cannot run away
  assign at_end = (value_reg >= max_val);
  assign carry = inc_en & at_end & ~load_en;

  always_comb begin
    value_next = value_reg;
    if (load_en) begin
      value_next = load_val;
    end else if (inc_en) begin
      if (at_end) begin
        value_next = min_val;
      end else if (value_reg[3:0] == 4'h9) begin
        value_next = {4'(value_reg[7:4] + 4'h1), 4'h0};
      end else begin
        value_next = {value_reg[7:4], 4'(value_reg[3:0] + 4'h1)};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule // bcd_field
`default_nettype wire

// *** hdl/tick_timer.sv ***
// periodic tick interrupt timer running from the 128 Hz enable
`timescale 1ns/1ns
`default_nettype none
module tick_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // rate and setup
  input wire logic tick_en,
  input wire logic load,
  input wire rtc_pkg::tick_s setup,
  // event
  output logic tick_irq
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic irq_reg;
  logic irq_next;
  logic at_zero;

  assign at_zero = (cnt_reg == 7'h00);

  // n, n-1 .. 0 then reload: n+1 ticks of 1/128 s per period
  always_comb begin
    cnt_next = cnt_reg;
    irq_next = 1'b0;
    if (load) begin
      cnt_next = setup.count;
    end else if (tick_en) begin
      if (at_zero) begin
        cnt_next = setup.count;
        irq_next = setup.irq_en;
      end else begin
        cnt_next = cnt_reg - 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'h00;
      irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      irq_reg <= irq_next;
    end
  end

  assign tick_irq = irq_reg;
endmodule // tick_timer
`default_nettype wire

// *** hdl/rtc_top.sv ***
// calendar clock core: apb registers, crystal divider, calendar, alarm and tick
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rtc_top #(
  parameter int SEC_DIVIDE = rtc_pkg::SEC_DIVIDE
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal timebase, one pulse per crystal period
  input wire logic xtal_tick,
  // system power state
  input wire logic power_off,
  // events
  output logic alarm_irq,
  output logic power_wakeup_request,
  output logic tick_irq
);
  localparam int TICK_DIV = SEC_DIVIDE / rtc_pkg::TICK_HZ;
  localparam int DIV_W = $clog2(SEC_DIVIDE);
  localparam int TDW = $clog2(TICK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_DIVIDE - 1);
  localparam logic [TDW-1:0] TICK_LAST = TDW'(TICK_DIV - 1);

  // ---------------------------------------------------------------- bus side
  logic setup_ph;
  logic wr_en;
  logic bus_open;
  logic [7:0] wbyte;

  // isolation: with system power off nothing on the bus reaches the block
  assign bus_open = ~power_off;
  assign setup_ph = psel & ~penable;
  // only byte lane 0 carries register data
  assign wr_en = psel & penable & pwrite & pstrb[0] & bus_open;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;

  // ------------------------------------------------------------- registers
  rtc_pkg::ctrl_s ctrl_reg;
  rtc_pkg::ctrl_s ctrl_next;
  rtc_pkg::tick_s tick_reg;
  rtc_pkg::tick_s tick_next;
  rtc_pkg::alarm_ctl_s alm_ctl_reg;
  rtc_pkg::alarm_ctl_s alm_ctl_next;
  logic [rtc_pkg::NALARM-1:0][7:0] alm_reg;
  logic [rtc_pkg::NALARM-1:0][7:0] alm_next;
  logic tick_load;

  always_comb begin
    ctrl_next = ctrl_reg;
    tick_next = tick_reg;
    alm_ctl_next = alm_ctl_reg;
    alm_next = alm_reg;
    tick_load = 1'b0;
    if (wr_en) begin
      if (paddr == rtc_pkg::CTRL_OFF) begin
        ctrl_next = rtc_pkg::ctrl_s'(wbyte[3:0]);
      end
      if (paddr == rtc_pkg::TICK_OFF) begin
        tick_next = rtc_pkg::tick_s'(wbyte);
        tick_load = 1'b1;
      end
      if (paddr == rtc_pkg::ALM_CTRL_OFF) begin
        alm_ctl_next = rtc_pkg::alarm_ctl_s'(wbyte[6:0]);
      end
      for (int k = 0; k < rtc_pkg::NALARM; k++) begin
        if (paddr == rtc_pkg::ALM_OFF[k]) begin
          alm_next[k] = wbyte & rtc_pkg::ALM_MASK[k];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= rtc_pkg::CTRL_RESET;
      tick_reg <= rtc_pkg::TICK_RESET;
      alm_ctl_reg <= rtc_pkg::ALM_CTL_RESET;
      alm_reg <= rtc_pkg::ALM_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      tick_reg <= tick_next;
      alm_ctl_reg <= alm_ctl_next;
      alm_reg <= alm_next;
    end
  end

  // --------------------------------------------------------- crystal divider
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic sec_en;
  logic tick128_en;

  always_comb begin
    div_next = div_reg;
    if (ctrl_reg.count_reset_bit) begin
      div_next = '0;
    end else if (xtal_tick) begin
      div_next = (div_reg == DIV_LAST) ? '0 : DIV_W'(div_reg + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // the test clock select makes every crystal period count as a second
  assign sec_en = xtal_tick & ~ctrl_reg.count_reset_bit &
                  (ctrl_reg.count_clock_select | (div_reg == DIV_LAST));
  assign tick128_en = xtal_tick & ~ctrl_reg.count_reset_bit &
                      (div_reg[TDW-1:0] == TICK_LAST);

  // ---------------------------------------------------------------- calendar
  logic [rtc_pkg::NFIELD-1:0][7:0] cal;
  logic [rtc_pkg::NFIELD-1:0][7:0] cal_max;
  logic [rtc_pkg::NFIELD-1:0] cal_inc;
  logic [rtc_pkg::NFIELD-1:0] cal_carry;
  logic [rtc_pkg::NFIELD-1:0] cal_load;
  logic leap;
  logic [7:0] last_day;
  logic [7:0] mon;
  logic [7:0] yr;

  assign mon = cal[rtc_pkg::F_MON];
  assign yr = cal[rtc_pkg::F_YEAR];

  // divisible by four in bcd: even tens with 0/4/8, odd tens with 2/6; 00 counts
  always_comb begin
    leap = 1'b0;
    if (!yr[4]) begin
      leap = (yr[3:0] == 4'h0) | (yr[3:0] == 4'h4) | (yr[3:0] == 4'h8);
    end else begin
      leap = (yr[3:0] == 4'h2) | (yr[3:0] == 4'h6);
    end
  end

  always_comb begin
    case (mon)
      rtc_pkg::FEB: last_day = leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = rtc_pkg::DAYS_30;
      default: last_day = rtc_pkg::DAYS_31;
    endcase
  end

  always_comb begin
    cal_max = rtc_pkg::CAL_MAX;
    cal_max[rtc_pkg::F_DATE] = last_day;
  end

  // weekday and date both step on the hour carry; month follows the date
  assign cal_inc[rtc_pkg::F_SEC] = sec_en;
  assign cal_inc[rtc_pkg::F_MIN] = cal_carry[rtc_pkg::F_SEC];
  assign cal_inc[rtc_pkg::F_HOUR] = cal_carry[rtc_pkg::F_MIN];
  assign cal_inc[rtc_pkg::F_DATE] = cal_carry[rtc_pkg::F_HOUR];
  assign cal_inc[rtc_pkg::F_WDAY] = cal_carry[rtc_pkg::F_HOUR];
  assign cal_inc[rtc_pkg::F_MON] = cal_carry[rtc_pkg::F_DATE];
  assign cal_inc[rtc_pkg::F_YEAR] = cal_carry[rtc_pkg::F_MON];

  genvar gi;
  generate
    for (gi = 0; gi < rtc_pkg::NFIELD; gi++) begin : g_field
      // a write in the same cycle as a count step wins over the step
      assign cal_load[gi] = wr_en & ctrl_reg.cpu_access_enable &
                            (paddr == rtc_pkg::CAL_OFF[gi]);
      bcd_field #(
        .RESET_VAL(rtc_pkg::CAL_RESET[gi])
      ) u_field (
        .pclk(pclk),
        .presetn(presetn),
        .inc_en(cal_inc[gi]),
        .load_en(cal_load[gi]),
        .load_val(wbyte & rtc_pkg::CAL_MASK[gi]),
        .min_val(rtc_pkg::CAL_MIN[gi]),
        .max_val(cal_max[gi]),
        .value(cal[gi]),
        .carry(cal_carry[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------- alarm
  logic [rtc_pkg::NALARM-1:0] alm_eq;
  logic match;
  logic match_reg;
  logic alarm_irq_reg;
  logic alarm_irq_next;
  logic wake_reg;
  logic wake_next;

  assign alm_eq[0] = (alm_reg[0] == cal[rtc_pkg::F_SEC]);
  assign alm_eq[1] = (alm_reg[1] == cal[rtc_pkg::F_MIN]);
  assign alm_eq[2] = (alm_reg[2] == cal[rtc_pkg::F_HOUR]);
  assign alm_eq[3] = (alm_reg[3] == cal[rtc_pkg::F_DATE]);
  assign alm_eq[4] = (alm_reg[4] == cal[rtc_pkg::F_MON]);
  assign alm_eq[5] = (alm_reg[5] == cal[rtc_pkg::F_YEAR]);

  // fields with their enable clear always agree
  assign match = alm_ctl_reg.alarm_global_enable &
                 (&(alm_eq | ~alm_ctl_reg.field_en));

  // edge of the match so a matching second raises one event, not one per cycle
  always_comb begin
    alarm_irq_next = match & ~match_reg;
    wake_next = match & ~match_reg & power_off;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_reg <= 1'b0;
      alarm_irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      match_reg <= match;
      alarm_irq_reg <= alarm_irq_next;
      wake_reg <= wake_next;
    end
  end

  assign alarm_irq = alarm_irq_reg;
  assign power_wakeup_request = wake_reg;

  // -------------------------------------------------------------- tick timer
  tick_timer u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_en(tick128_en),
    .load(tick_load),
    .setup(tick_reg),
    .tick_irq(tick_irq)
  );

  // ---------------------------------------------------------------- readback
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b0;
    if (paddr == rtc_pkg::CTRL_OFF) begin
      rd_byte = {4'h0, ctrl_reg};
      rd_hit = 1'b1;
    end
    if (paddr == rtc_pkg::TICK_OFF) begin
      rd_byte = tick_reg;
      rd_hit = 1'b1;
    end
    if (paddr == rtc_pkg::ALM_CTRL_OFF) begin
      rd_byte = {1'b0, alm_ctl_reg};
      rd_hit = 1'b1;
    end
    for (int k = 0; k < rtc_pkg::NALARM; k++) begin
      if (paddr == rtc_pkg::ALM_OFF[k]) begin
        rd_byte = alm_reg[k];
        rd_hit = 1'b1;
      end
    end
    for (int k = 0; k < rtc_pkg::NFIELD; k++) begin
      if (paddr == rtc_pkg::CAL_OFF[k]) begin
        rd_byte = cal[k];
        rd_hit = 1'b1;
      end
    end
  end

  // data is captured in the setup phase and stands through the access phase
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_ph) begin
      prdata_next = bus_open ? {24'h000000, rd_byte} : 32'h00000000;
      pslverr_next = bus_open & ~rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;
endmodule // rtc_top
`default_nettype wire

// *** tb/rtc_top_assertions.sv ***
// checker of alarm, tick and bus isolation behaviour at the clock core ports
`timescale 1ns/1ns
`default_nettype none
module rtc_top_checker #(
  parameter int SEC_DIVIDE = rtc_pkg::SEC_DIVIDE
) (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // timebase, power and events
  input wire logic xtal_tick,
  input wire logic power_off,
  input wire logic alarm_irq,
  input wire logic power_wakeup_request,
  input wire logic tick_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wake_needs_off;
    power_wakeup_request |-> $past(power_off);
  endproperty
  a_wake_needs_off: assert property (p_wake_needs_off) else $error("wakeup in normal mode");
  property p_wake_with_alarm;
    power_wakeup_request |-> alarm_irq;
  endproperty
  a_wake_with_alarm: assert property (p_wake_with_alarm) else $error("wakeup alone");
  property p_alarm_wakes;
    alarm_irq && $past(power_off) |-> power_wakeup_request;
  endproperty
  a_alarm_wakes: assert property (p_alarm_wakes) else $error("alarm without wakeup");
  property p_alarm_once;
    alarm_irq |=> !alarm_irq;
  endproperty
  a_alarm_once: assert property (p_alarm_once) else $error("alarm longer than one cycle");
  property p_tick_pulse;
    tick_irq |=> !tick_irq;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
  property p_tick_from_xtal;
    tick_irq |-> $past(xtal_tick);
  endproperty
  a_tick_from_xtal: assert property (p_tick_from_xtal) else $error("tick without timebase");
  property p_isolate_read;
    power_off && psel && !penable |=> prdata == 32'h00000000;
  endproperty
  a_isolate_read: assert property (p_isolate_read) else $error("read data in power-off");
  property p_isolate_err;
    power_off && psel && penable |-> !pslverr;
  endproperty
  a_isolate_err: assert property (p_isolate_err) else $error("error in power-off");
endmodule // rtc_top_checker
bind rtc_top rtc_top_checker #(.SEC_DIVIDE(SEC_DIVIDE)) chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .xtal_tick, .power_off,
  .alarm_irq, .power_wakeup_request, .tick_irq);
`default_nettype wire

// *** tb/apb_host.sv ***
// processor-side bus model: byte transfers and the calendar read sequence
`timescale 1ns/1ns
`default_nettype none
module apb_host (
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [7:0] rd;
  logic err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end
  // one idle cycle follows each transfer so no signal is assigned twice in a step
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, wd};
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // year first; a zero second may hide a carry, so the set is read once more
  task automatic read_time(output logic [6:0][7:0] t);
    for (int pass = 0; pass < 2; pass++) begin
      for (int i = 6; i >= 0; i--) begin
        xfer(1'b0, rtc_pkg::CAL_OFF[i], 8'h00);
        t[i] = rd;
      end
      if (t[0] !== 8'h00) break;
    end
  endtask
endmodule // apb_host
`default_nettype wire

// *** tb/test_bcd_calendar_rtc_with_alarm_tick.sv ***
// self-checking bench of the calendar clock core
`timescale 1ns/1ns
`default_nettype none
module test_bcd_calendar_rtc_with_alarm_tick;
  localparam int SD = 256;
  localparam int LIMIT = 20000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic xtal_tick = 1'b0;
  logic power_off = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, alarm_irq, power_wakeup_request, tick_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int alm_n = 0;
  int wake_n = 0;
  int tick_last = 0;
  int tick_gap = 0;

  always #4 pclk = ~pclk;

  apb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr);
  rtc_top #(.SEC_DIVIDE(SD)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .xtal_tick, .power_off, .alarm_irq,
    .power_wakeup_request, .tick_irq);

  always @(posedge pclk) begin
    cyc++;
    if (alarm_irq === 1'b1) alm_n++;
    if (power_wakeup_request === 1'b1) wake_n++;
    if (tick_irq === 1'b1) begin
      tick_gap = cyc - tick_last;
      tick_last = cyc;
    end
    if (cyc == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    host.xfer(1'b0, addr, 8'h00);
    check(host.rd, exp);
  endtask

  // one crystal pulse every other bus clock
  task automatic xt(input int n);
    repeat (n) begin
      xtal_tick <= 1'b1;
      @(posedge pclk);
      xtal_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic t_reset;
    for (int i = 0; i < rtc_pkg::NFIELD; i++) rdc(rtc_pkg::CAL_OFF[i], rtc_pkg::CAL_RESET[i]);
    for (int i = 0; i < rtc_pkg::NALARM; i++) rdc(rtc_pkg::ALM_OFF[i], rtc_pkg::ALM_RESET[i]);
    rdc(rtc_pkg::CTRL_OFF, 8'h00);
    rdc(rtc_pkg::TICK_OFF, 8'h00);
    rdc(rtc_pkg::ALM_CTRL_OFF, 8'h00);
    rdc(8'h4C, 8'h00);
    check({7'h00, host.err}, 8'h01);
  endtask

  task automatic t_gate;
    host.xfer(1'b1, rtc_pkg::CAL_OFF[0], 8'h30);
    rdc(rtc_pkg::CAL_OFF[0], 8'h00);
    host.xfer(1'b1, rtc_pkg::CTRL_OFF, 8'hFF);
    rdc(rtc_pkg::CTRL_OFF, 8'h0F);
    host.xfer(1'b1, rtc_pkg::CTRL_OFF, 8'h03);
    host.xfer(1'b1, rtc_pkg::CAL_OFF[0], 8'h30);
    rdc(rtc_pkg::CAL_OFF[0], 8'h30);
  endtask

  // each case: date, month, year before one step from 23:59:59, then expected after
  task automatic t_cal;
    logic [47:0] cases [7];
    logic [6:0][7:0] t, v, e;
    cases = '{48'h280200290200, 48'h290200010300, 48'h280201010301, 48'h280204290204,
      48'h300423010523, 48'h300123310123, 48'h311299010100};
    foreach (cases[k]) begin
      v = {cases[k][31:24], cases[k][39:32], 8'h07, cases[k][47:40], 8'h23, 8'h59, 8'h59};
      e = {cases[k][7:0], cases[k][15:8], 8'h01, cases[k][23:16], 8'h00, 8'h00, 8'h00};
      for (int i = 6; i >= 0; i--) host.xfer(1'b1, rtc_pkg::CAL_OFF[i], v[i]);
      xt(1);
      host.read_time(t);
      for (int i = 0; i < 7; i++) check(t[i], e[i]);
    end
  endtask

  task automatic t_alarm;
    int a0, w0;
    host.xfer(1'b1, rtc_pkg::ALM_OFF[0], 8'h03);
    host.xfer(1'b1, rtc_pkg::ALM_CTRL_OFF, 8'h41);
    a0 = alm_n;
    w0 = wake_n;
    xt(5);
    check(8'(alm_n - a0), 8'h01);
    check(8'(wake_n - w0), 8'h00);
    host.xfer(1'b1, rtc_pkg::ALM_CTRL_OFF, 8'h01);
    a0 = alm_n;
    xt(60);
    check(8'(alm_n - a0), 8'h00);
    host.xfer(1'b1, rtc_pkg::ALM_CTRL_OFF, 8'h41);
    power_off <= 1'b1;
    rdc(rtc_pkg::ALM_CTRL_OFF, 8'h00);
    host.xfer(1'b1, rtc_pkg::ALM_CTRL_OFF, 8'h00);
    a0 = alm_n;
    w0 = wake_n;
    xt(60);
    check(8'(alm_n - a0), 8'h01);
    check(8'(wake_n - w0), 8'h01);
    power_off <= 1'b0;
    rdc(rtc_pkg::ALM_CTRL_OFF, 8'h41);
  endtask

  task automatic t_tick;
    logic [6:0] ns [2];
    int t0;
    ns = '{7'h01, 7'h3F};
    host.xfer(1'b1, rtc_pkg::CTRL_OFF, 8'h01);
    foreach (ns[k]) begin
      host.xfer(1'b1, rtc_pkg::TICK_OFF, {1'b1, ns[k]});
      rdc(rtc_pkg::TICK_OFF, {1'b1, ns[k]});
      xtal_tick <= 1'b1;
      repeat ((ns[k] + 1) * (SD / 128) * 3) @(posedge pclk);
      xtal_tick <= 1'b0;
      check(8'(tick_gap), 8'((ns[k] + 1) * (SD / 128)));
    end
    host.xfer(1'b1, rtc_pkg::TICK_OFF, 8'h05);
    t0 = tick_last;
    xtal_tick <= 1'b1;
    repeat (40) @(posedge pclk);
    xtal_tick <= 1'b0;
    check(8'(tick_last - t0), 8'h00);
  endtask

  // count reset freezes the divider; once freed a second takes SD crystal pulses
  task automatic t_div;
    host.xfer(1'b1, rtc_pkg::CTRL_OFF, 8'h09);
    host.xfer(1'b1, rtc_pkg::CAL_OFF[0], 8'h00);
    xt(SD);
    rdc(rtc_pkg::CAL_OFF[0], 8'h00);
    host.xfer(1'b1, rtc_pkg::CTRL_OFF, 8'h01);
    xt(SD - 1);
    rdc(rtc_pkg::CAL_OFF[0], 8'h00);
    xt(1);
    rdc(rtc_pkg::CAL_OFF[0], 8'h01);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gate();
    t_cal();
    t_alarm();
    t_tick();
    t_div();
    print_verdict();
  end
endmodule // test_bcd_calendar_rtc_with_alarm_tick
`default_nettype wire
